// ===== include/spcr_pkg.sv
package spcr_pkg;
  // ****************************************
  // Register byte addresses (index times 4)
  // ****************************************
  localparam logic [7:0] CTL_FIRST_IDX = 8'h00;
  localparam logic [7:0] CTL_SECOND_IDX = 8'h02;
  localparam logic [7:0] DEF_TAG_IDX = 8'h04;
  localparam logic [7:0] CTL_FIRST_ADDR = 8'(CTL_FIRST_IDX * 4);
  localparam logic [7:0] CTL_SECOND_ADDR = 8'(CTL_SECOND_IDX * 4);
  localparam logic [7:0] DEF_TAG_ADDR = 8'(DEF_TAG_IDX * 4);
  // ****************************************
  // First control register fields
  // ****************************************
  localparam int DSCP_EN_BIT = 6;
  localparam int DOT1P_EN_BIT = 5;
  localparam int PORT_PRIO_LSB = 3;
  localparam int TAG_INS_BIT = 2;
  localparam int TAG_REM_BIT = 1;
  localparam int MULTI_Q_BIT = 0;
  localparam logic [15:0] CTL_FIRST_MASK = 16'h007F;
  localparam logic [15:0] CTL_FIRST_RST = 16'h0000;
  // ****************************************
  // Second control register fields
  // ****************************************
  localparam int VLAN_FILT_BIT = 14;
  localparam int NON_PVID_BIT = 13;
  localparam int FORCE_FC_BIT = 12;
  localparam int BACK_PRES_BIT = 11;
  localparam int TX_EN_BIT = 10;
  localparam int RX_EN_BIT = 9;
  localparam int LEARN_DIS_BIT = 8;
  localparam int MIRROR_DST_BIT = 7;
  localparam int RX_SNIFF_BIT = 6;
  localparam int TX_SNIFF_BIT = 5;
  localparam int PRIO_CEIL_BIT = 3;
  localparam int MEMBER_LSB = 0;
  localparam logic [15:0] CTL_SECOND_MASK = 16'h7FEF;
  localparam logic [15:0] CTL_SECOND_RST = 16'h0607;
  // ****************************************
  // Default tag register fields
  // ****************************************
  localparam int USER_PRIO_LSB = 13;
  localparam int VID_LSB = 0;
  localparam logic [15:0] DEF_TAG_RST = 16'h0001;
endpackage

// ===== core/spcr_port_regs.sv
`timescale 1ns/10ps
// Behaviour
// RL1: control-first bit 6 enables DiffServ code point ingress classification.
// RL2: control-first bit 5 enables 802.1p ingress classification.
// RL3: port priority field picks queue 0..3 when neither classifier gives a result.
// RL4: OR of 802.1p and DiffServ priorities overrides the port priority.
// RL5: tag insertion bit 2 tags untagged frames with ingress port default VID.
// RL6: tag removal bit 1 strips tags from frames received tagged.
// RL7: bit 0 selects four egress queues; cleared means one queue.
// RL8: ingress filter bit 14 drops frames whose VLAN membership excludes this port.
// RL9: bit 13 drops frames whose VID differs from the port default VID.
// RL10: force flow control bit 12 overrides the negotiated pause result.
// RL11: bit 11 enables half-duplex back pressure.
// RL12: bit 10 enables transmission, set after reset.
// RL13: bit 9 enables reception, set after reset.
// RL14: bit 8 set stops source address learning on this port.
// RL15: bit 7 makes this port the mirror destination.
// RL16: second bit 6 marks received frames monitored and mirrors them.
// RL17: second bit 5 marks transmitted frames monitored and mirrors them.
// RL18: ceiling bit 3 caps frame priority at default-tag user priority.
// RL19: membership field, reset all ones, restricts which ports exchange frames.
// RL20: membership bit 2 host, bit 1 second port, bit 0 first port.
// RL21: default tag register holds 12-bit default VID, reset to 1.
// RL22: reserved bits read zero and writes to them do nothing.
module spcr_port_regs (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Ingress frame descriptor
  input wire logic ing_valid_in,
  input wire logic ing_tagged_in,
  input wire logic [11:0] ing_vid_in,
  input wire logic [2:0] ing_tag_prio_in,
  input wire logic ing_dscp_hit_in,
  input wire logic [1:0] ing_dscp_prio_in,
  input wire logic ing_dot1p_hit_in,
  input wire logic [1:0] ing_dot1p_prio_in,
  input wire logic [2:0] ing_vlan_member_in,
  input wire logic [2:0] ing_dest_mask_in,
  // Egress frame descriptor
  input wire logic egr_valid_in,
  input wire logic egr_rx_tagged_in,
  input wire logic [11:0] egr_src_vid_in,
  input wire logic [1:0] egr_prio_in,
  // Link status
  input wire logic aneg_pause_in,
  // Ingress decisions
  output logic ing_done_out,
  output logic ing_drop_out,
  output logic [1:0] ing_queue_prio_out,
  output logic [2:0] ing_new_prio_out,
  output logic [2:0] ing_fwd_mask_out,
  output logic ing_learn_out,
  output logic ing_monitor_out,
  // Egress decisions
  output logic egr_done_out,
  output logic egr_insert_tag_out,
  output logic egr_strip_tag_out,
  output logic [11:0] egr_tag_vid_out,
  output logic [1:0] egr_queue_out,
  output logic egr_monitor_out,
  // Port levels
  output logic flow_ctrl_out,
  output logic back_pressure_out,
  output logic tx_enable_out,
  output logic rx_enable_out,
  output logic mirror_dest_out
);

  // ****************************************
  // Register storage and bus state
  // ****************************************
  logic [15:0] ctl_first_reg;
  logic [15:0] ctl_second_reg;
  logic [15:0] def_tag_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic bus_req;
  logic bus_ack;
  logic [15:0] wdata;
  logic [15:0] rd_mux;

  // Request is accepted only in the cycle waitrequest is low
  assign bus_req = avs_read_in | avs_write_in;
  assign bus_ack = bus_req & ~wait_reg;
  assign wdata = avs_writedata_in[15:0];

  // One wait cycle per access keeps read data registered
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
    end
  end

  // Byte lane merge; upper lanes hold no storage
  function automatic logic [15:0] spcr_merge(input logic [15:0] old_val, input logic [15:0] mask);
    logic [15:0] val;
    val = old_val;
    if (avs_byteenable_in[0]) begin
      val[7:0] = wdata[7:0];
    end
    if (avs_byteenable_in[1]) begin
      val[15:8] = wdata[15:8];
    end
    return val & mask;
  endfunction

  // RL22: reserved bits masked
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_first_reg <= spcr_pkg::CTL_FIRST_RST;
      ctl_second_reg <= spcr_pkg::CTL_SECOND_RST;
    end else if (bus_ack && avs_write_in) begin
      if (avs_address_in == spcr_pkg::CTL_FIRST_ADDR) begin
        ctl_first_reg <= spcr_merge(ctl_first_reg, spcr_pkg::CTL_FIRST_MASK);
      end
      if (avs_address_in == spcr_pkg::CTL_SECOND_ADDR) begin
        ctl_second_reg <= spcr_merge(ctl_second_reg, spcr_pkg::CTL_SECOND_MASK);
      end
    end
  end

  // RL21: default tag storage
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      def_tag_reg <= spcr_pkg::DEF_TAG_RST;
    end else if (bus_ack && avs_write_in && avs_address_in == spcr_pkg::DEF_TAG_ADDR) begin
      def_tag_reg <= spcr_merge(def_tag_reg, 16'hFFFF);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (avs_address_in)
      spcr_pkg::CTL_FIRST_ADDR: rd_mux = ctl_first_reg;
      spcr_pkg::CTL_SECOND_ADDR: rd_mux = ctl_second_reg;
      spcr_pkg::DEF_TAG_ADDR: rd_mux = def_tag_reg;
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data captured as the wait is dropped
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_in && wait_reg) begin
      rdata_reg <= {16'h0000, rd_mux};
    end
  end

  assign avs_readdata_out = rdata_reg;
  assign avs_waitrequest_out = wait_reg;

  // ****************************************
  // Field decode
  // ****************************************
  logic dscp_en;
  logic dot1p_en;
  logic [1:0] port_prio;
  logic [2:0] member;
  logic [2:0] user_prio;
  logic [11:0] def_vid;
  logic [11:0] frame_vid;
  logic cls_hit;
  logic [1:0] cls_prio;
  logic ing_drop;

  assign dscp_en = ctl_first_reg[spcr_pkg::DSCP_EN_BIT];
  assign dot1p_en = ctl_first_reg[spcr_pkg::DOT1P_EN_BIT];
  assign port_prio = ctl_first_reg[spcr_pkg::PORT_PRIO_LSB +: 2];
  // RL20: bit order host, second, first
  assign member = ctl_second_reg[spcr_pkg::MEMBER_LSB +: 3];
  assign user_prio = def_tag_reg[spcr_pkg::USER_PRIO_LSB +: 3];
  assign def_vid = def_tag_reg[spcr_pkg::VID_LSB +: 12];
  // RL21: untagged frames take the default VID
  assign frame_vid = ing_tagged_in ? ing_vid_in : def_vid;

  // RL1: DiffServ result gated by its enable
  // RL2: 802.1p result gated by its enable
  // RL4: OR of both classifiers
  always_comb begin
    cls_hit = (dscp_en & ing_dscp_hit_in) | (dot1p_en & ing_dot1p_hit_in);
    cls_prio = ((dscp_en & ing_dscp_hit_in) ? ing_dscp_prio_in : 2'b00)
             | ((dot1p_en & ing_dot1p_hit_in) ? ing_dot1p_prio_in : 2'b00);
  end

  // RL8: membership filter
  // RL9: default VID match
  // RL13: reception gate
  assign ing_drop = ~ctl_second_reg[spcr_pkg::RX_EN_BIT]
    | (ctl_second_reg[spcr_pkg::VLAN_FILT_BIT] & ~ing_vlan_member_in[0])
    | (ctl_second_reg[spcr_pkg::NON_PVID_BIT] & (frame_vid != def_vid));

  // ****************************************
  // Ingress decisions
  // ****************************************
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ing_done_out <= 1'b0;
      ing_drop_out <= 1'b0;
    end else begin
      ing_done_out <= ing_valid_in;
      ing_drop_out <= ing_valid_in & ing_drop;
    end
  end

  // RL3: port priority as fallback
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ing_queue_prio_out <= 2'b00;
    end else if (ing_valid_in) begin
      ing_queue_prio_out <= cls_hit ? cls_prio : port_prio;
    end
  end

  // RL18: priority ceiling
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ing_new_prio_out <= 3'b000;
    end else if (ing_valid_in) begin
      if (ctl_second_reg[spcr_pkg::PRIO_CEIL_BIT] && ing_tag_prio_in > user_prio) begin
        ing_new_prio_out <= user_prio;
      end else begin
        ing_new_prio_out <= ing_tag_prio_in;
      end
    end
  end

  // RL19: forwarding limited to members; dropped frames go nowhere
  // RL14: learning suppressed when disabled
  // RL16: receive mirroring
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ing_fwd_mask_out <= 3'b000;
      ing_learn_out <= 1'b0;
      ing_monitor_out <= 1'b0;
    end else begin
      ing_fwd_mask_out <= (ing_valid_in && !ing_drop) ? (ing_dest_mask_in & member) : 3'b000;
      ing_learn_out <= ing_valid_in & ~ing_drop & ~ctl_second_reg[spcr_pkg::LEARN_DIS_BIT];
      ing_monitor_out <= ing_valid_in & ~ing_drop & ctl_second_reg[spcr_pkg::RX_SNIFF_BIT];
    end
  end

  // ****************************************
  // Egress decisions
  // ****************************************
  logic egr_go;

  // RL12: transmission gate
  assign egr_go = egr_valid_in & ctl_second_reg[spcr_pkg::TX_EN_BIT];

  // RL5: insert only on untagged frames
  // RL6: strip only on tagged frames
  // RL17: transmit mirroring
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      egr_done_out <= 1'b0;
      egr_insert_tag_out <= 1'b0;
      egr_strip_tag_out <= 1'b0;
      egr_monitor_out <= 1'b0;
    end else begin
      egr_done_out <= egr_go;
      egr_insert_tag_out <= egr_go & ctl_first_reg[spcr_pkg::TAG_INS_BIT] & ~egr_rx_tagged_in;
      egr_strip_tag_out <= egr_go & ctl_first_reg[spcr_pkg::TAG_REM_BIT] & egr_rx_tagged_in;
      egr_monitor_out <= egr_go & ctl_second_reg[spcr_pkg::TX_SNIFF_BIT];
    end
  end

  // RL7: single queue flattens priority
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      egr_queue_out <= 2'b00;
      egr_tag_vid_out <= 12'h000;
    end else if (egr_go) begin
      egr_queue_out <= ctl_first_reg[spcr_pkg::MULTI_Q_BIT] ? egr_prio_in : 2'b00;
      egr_tag_vid_out <= egr_src_vid_in;
    end
  end

  // ****************************************
  // Port levels
  // ****************************************
  // RL10: force overrides negotiation
  // RL11: back pressure level
  // RL15: mirror destination level
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flow_ctrl_out <= 1'b0;
      back_pressure_out <= 1'b0;
      tx_enable_out <= 1'b0;
      rx_enable_out <= 1'b0;
      mirror_dest_out <= 1'b0;
    end else begin
      flow_ctrl_out <= ctl_second_reg[spcr_pkg::FORCE_FC_BIT] | aneg_pause_in;
      back_pressure_out <= ctl_second_reg[spcr_pkg::BACK_PRES_BIT];
      tx_enable_out <= ctl_second_reg[spcr_pkg::TX_EN_BIT];
      rx_enable_out <= ctl_second_reg[spcr_pkg::RX_EN_BIT];
      mirror_dest_out <= ctl_second_reg[spcr_pkg::MIRROR_DST_BIT];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_RSVD_ZERO: assert property ((ctl_first_reg & ~spcr_pkg::CTL_FIRST_MASK) == 16'h0000 // RL22
    && (ctl_second_reg & ~spcr_pkg::CTL_SECOND_MASK) == 16'h0000)
    else $error("reserved bit set");
  AST_PORT_PRIO: assert property (ing_valid_in && !cls_hit |=> ing_queue_prio_out == $past(port_prio)) // RL3
    else $error("fallback priority wrong");
  AST_CLS_PRIO: assert property (ing_valid_in && dot1p_en && ing_dot1p_hit_in // RL4
    |=> ing_queue_prio_out[1:0] >= $past(ing_dot1p_prio_in))
    else $error("classifier priority lost");
  AST_DSCP_OFF: assert property (ing_valid_in && !dscp_en && !dot1p_en // RL1
    |=> ing_queue_prio_out == $past(port_prio))
    else $error("disabled classifier used");
  AST_INSERT: assert property (egr_insert_tag_out |-> !egr_strip_tag_out) // RL5
    else $error("insert and strip together");
  AST_INS_UNTAG: assert property (egr_go && ctl_first_reg[spcr_pkg::TAG_INS_BIT] // RL5
    |=> egr_insert_tag_out != $past(egr_rx_tagged_in))
    else $error("tag insertion wrong");
  AST_STRIP: assert property (egr_go && ctl_first_reg[spcr_pkg::TAG_REM_BIT] // RL6
    |=> egr_strip_tag_out == $past(egr_rx_tagged_in))
    else $error("tag removal wrong");
  AST_SINGLE_Q: assert property (egr_go && !ctl_first_reg[spcr_pkg::MULTI_Q_BIT] // RL7
    |=> egr_queue_out == 2'b00)
    else $error("single queue not flat");
  AST_VLAN_DROP: assert property (ing_valid_in && ctl_second_reg[spcr_pkg::VLAN_FILT_BIT] // RL8
    && !ing_vlan_member_in[0] |=> ing_drop_out && ing_fwd_mask_out == 3'b000)
    else $error("nonmember frame kept");
  AST_PVID_KEEP: assert property (ing_valid_in && !ctl_second_reg[spcr_pkg::NON_PVID_BIT] // RL9
    && ctl_second_reg[spcr_pkg::RX_EN_BIT] && !ctl_second_reg[spcr_pkg::VLAN_FILT_BIT] |=> !ing_drop_out)
    else $error("frame dropped for VID");
  AST_FORCE_FC: assert property (ctl_second_reg[spcr_pkg::FORCE_FC_BIT] |=> flow_ctrl_out) // RL10
    else $error("forced flow control off");
  AST_CEIL: assert property (ing_valid_in && ctl_second_reg[spcr_pkg::PRIO_CEIL_BIT] // RL18
    |=> ing_new_prio_out <= $past(user_prio))
    else $error("ceiling exceeded");
  AST_MEMBER: assert property ((ing_fwd_mask_out & ~member) == 3'b000 || $changed(member)) // RL19
    else $error("nonmember port forwarded");
  AST_TX_GATE: assert property (!ctl_second_reg[spcr_pkg::TX_EN_BIT] |=> !egr_done_out) // RL12
    else $error("transmit while disabled");
  AST_BUS_ACK: assert property (bus_req && wait_reg |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("wait cycle length wrong");

  COV_WRITE: cover property (avs_write_in && !avs_waitrequest_out);
  COV_READ: cover property (avs_read_in && !avs_waitrequest_out);
  COV_DROP: cover property (ing_drop_out);
  COV_INSERT: cover property (egr_insert_tag_out);
endmodule

// ===== verification/tb_switch_port_control_regs.sv
`timescale 1ns/10ps
module tb_switch_port_control_regs;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic core_clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic iv = 1'h0;
  logic itag = 1'h0;
  logic [11:0] ivid = 12'h000;
  logic [2:0] itp = 3'h0;
  logic idh = 1'h0;
  logic [1:0] idp = 2'h0;
  logic iph = 1'h0;
  logic [1:0] ipp = 2'h0;
  logic [2:0] ivm = 3'h0;
  logic [2:0] idst = 3'h0;
  logic ev = 1'h0;
  logic etag = 1'h0;
  logic [11:0] evid = 12'h000;
  logic [1:0] ep = 2'h0;
  logic pause = 1'h0;
  logic [31:0] rdata;
  logic wait_req, idone, idrop, ilearn, imon, edone, eins, estr, emon, fc, bp, txe, rxe, mdst;
  logic [1:0] iq, eq, qe;
  logic [2:0] inp, ifwd;
  logic [11:0] etv, vv;
  logic [5:0] b;
  logic drop;
  int errors = 0;
  int compares = 0;

  // Design under test, every input driven by the bench
  spcr_port_regs uut (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req), .ing_valid_in(iv), .ing_tagged_in(itag), .ing_vid_in(ivid),
    .ing_tag_prio_in(itp), .ing_dscp_hit_in(idh), .ing_dscp_prio_in(idp), .ing_dot1p_hit_in(iph),
    .ing_dot1p_prio_in(ipp), .ing_vlan_member_in(ivm), .ing_dest_mask_in(idst), .egr_valid_in(ev),
    .egr_rx_tagged_in(etag), .egr_src_vid_in(evid), .egr_prio_in(ep), .aneg_pause_in(pause),
    .ing_done_out(idone), .ing_drop_out(idrop), .ing_queue_prio_out(iq), .ing_new_prio_out(inp),
    .ing_fwd_mask_out(ifwd), .ing_learn_out(ilearn), .ing_monitor_out(imon), .egr_done_out(edone),
    .egr_insert_tag_out(eins), .egr_strip_tag_out(estr), .egr_tag_vid_out(etv), .egr_queue_out(eq),
    .egr_monitor_out(emon), .flow_ctrl_out(fc), .back_pressure_out(bp), .tx_enable_out(txe),
    .rx_enable_out(rxe), .mirror_dest_out(mdst)
  );

  // 100 MHz clock
  always #5 core_clk_in = ~core_clk_in;

  // ****************************************
  // Bus, compare and closing tasks
  // ****************************************
  task automatic results;
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected register value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected port outputs at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until the edge that sees waitrequest low; bounded so a dead slave cannot hang us
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] en,
                     output logic [31:0] q);
    int n;
    @(posedge core_clk_in);
    addr <= a;
    rd <= ~w;
    wr <= w;
    wdata <= {16'h0000, d};
    be <= en;
    n = 0;
    do begin
      @(negedge core_clk_in);
      n++;
    end while (wait_req !== 1'h0 && n < 20);
    if (n >= 20) begin
      errors++;
    end
    q = rdata;
    @(posedge core_clk_in);
    rd <= 1'h0;
    wr <= 1'h0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d, input logic [3:0] en);
    logic [31:0] q;
    bus(1'h1, a, d, en, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 16'h0000, 4'hF, q);
    chk_reg(q, {16'h0000, exp});
  endtask

  // Drop descriptor strobes after one cycle, then look at the answer mid-cycle
  task automatic end_pulse;
    @(posedge core_clk_in);
    iv <= 1'h0;
    ev <= 1'h0;
    @(negedge core_clk_in);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge core_clk_in);
    reset_n_in <= 1'h1;
    // Levels follow the registers only from the first edge after release
    repeat (2) @(negedge core_clk_in);
    chk_out(20'({txe, rxe, fc, bp, mdst}), 20'h0_0018); // levels after reset
    rd_chk(spcr_pkg::CTL_FIRST_ADDR, 16'h0000); // reset value
    rd_chk(spcr_pkg::CTL_SECOND_ADDR, 16'h0607); // reset value
    rd_chk(spcr_pkg::DEF_TAG_ADDR, 16'h0001); // reset value
    // Reserved bits, byte lanes and an unmapped place
    wr_reg(spcr_pkg::CTL_FIRST_ADDR, 16'hFFFF, 4'hF);
    rd_chk(spcr_pkg::CTL_FIRST_ADDR, 16'h007F); // reserved bits
    wr_reg(spcr_pkg::CTL_FIRST_ADDR, 16'h0000, 4'hC);
    rd_chk(spcr_pkg::CTL_FIRST_ADDR, 16'h007F); // upper lanes ignored
    wr_reg(spcr_pkg::CTL_SECOND_ADDR, 16'hFFFF, 4'hF);
    rd_chk(spcr_pkg::CTL_SECOND_ADDR, 16'h7FEF); // reserved bits
    wr_reg(spcr_pkg::CTL_SECOND_ADDR, 16'h0000, 4'h1);
    rd_chk(spcr_pkg::CTL_SECOND_ADDR, 16'h7F00); // low lane only
    wr_reg(8'h18, 16'hFFFF, 4'hF);
    rd_chk(8'h18, 16'h0000); // unmapped reads zero
    wr_reg(spcr_pkg::DEF_TAG_ADDR, 16'h6123, 4'hF);
    rd_chk(spcr_pkg::DEF_TAG_ADDR, 16'h6123); // read back
    wr_reg(spcr_pkg::CTL_SECOND_ADDR, 16'h0607, 4'hF);
    // Every mix of classifier enables, hits and port priority
    for (int i = 0; i < 64; i++) begin
      b = 6'(i);
      wr_reg(spcr_pkg::CTL_FIRST_ADDR, {9'h000, b[0], b[1], b[5:4], 3'h0}, 4'hF);
      @(posedge core_clk_in);
      iv <= 1'h1;
      idh <= b[2];
      iph <= b[3];
      idp <= 2'h1;
      ipp <= 2'h2;
      end_pulse();
      qe = ((b[0] & b[2]) ? 2'h1 : 2'h0) | ((b[1] & b[3]) ? 2'h2 : 2'h0);
      if (qe === 2'h0) begin
        qe = b[5:4];
      end
      chk_out(20'(iq), 20'(qe));
    end
    // Filtering, learning, receive mirroring, ceiling and membership
    for (int i = 0; i < 64; i++) begin
      b = 6'(i);
      wr_reg(spcr_pkg::CTL_SECOND_ADDR, {1'h0, b[0], b[1], 3'h1, ~b[2], b[3], 1'h0, b[4], 2'h0, b[5],
                                         b[2:0] ^ 3'h2}, 4'hF);
      @(posedge core_clk_in);
      iv <= 1'h1;
      itag <= b[1] ^ b[4];
      ivid <= b[3] ? 12'h123 : 12'h0F0;
      itp <= {b[4], b[2], b[0]};
      ivm <= {2'h3, b[5] ^ b[3]};
      idst <= 3'h7 ^ {b[0], 1'h0, b[3]};
      end_pulse();
      vv = (b[1] ^ b[4]) ? (b[3] ? 12'h123 : 12'h0F0) : 12'h123;
      drop = b[2] | (b[0] & ~(b[5] ^ b[3])) | (b[1] & (vv !== 12'h123));
      chk_out(20'({idone, idrop, ifwd, ilearn, imon}), 20'({1'h1, drop, drop ? 3'h0 :
              (3'h7 ^ {b[0], 1'h0, b[3]}) & (b[2:0] ^ 3'h2), ~drop & ~b[3], ~drop & b[4]}));
      if (!drop) begin
        chk_out(20'(inp), 20'((b[5] && {b[4], b[2], b[0]} > 3'h3) ? 3'h3 : {b[4], b[2], b[0]}));
      end
    end
    // Egress tagging, queue mode, transmit enable and transmit mirroring
    for (int i = 0; i < 32; i++) begin
      b = 6'(i);
      wr_reg(spcr_pkg::CTL_FIRST_ADDR, {13'h0000, b[0], b[1], b[2]}, 4'hF);
      wr_reg(spcr_pkg::CTL_SECOND_ADDR, {5'h00, b[3], 1'h1, 3'h0, b[4], 5'h07}, 4'hF);
      @(posedge core_clk_in);
      ev <= 1'h1;
      etag <= b[2] ^ b[4];
      evid <= {b[4:0], 7'h15};
      ep <= b[1:0] ^ 2'h2;
      end_pulse();
      chk_out(20'({edone, eins, estr, emon}), 20'({b[3], b[3] & b[0] & ~(b[2] ^ b[4]),
              b[3] & b[1] & (b[2] ^ b[4]), b[3] & b[4]}));
      if (b[3]) begin
        chk_out(20'({eq, etv}), 20'({b[2] ? (b[1:0] ^ 2'h2) : 2'h0, b[4:0], 7'h15}));
      end
    end
    // Port level controls against the negotiated pause input
    for (int i = 0; i < 32; i++) begin
      b = 6'(i);
      @(posedge core_clk_in);
      pause <= b[2] ^ b[4];
      wr_reg(spcr_pkg::CTL_SECOND_ADDR, {3'h0, b[0], b[1], b[2], b[3], 1'h0, b[4], 7'h07}, 4'hF);
      repeat (2) @(negedge core_clk_in);
      chk_out(20'({fc, bp, txe, rxe, mdst}), 20'({b[0] | (b[2] ^ b[4]), b[1], b[2], b[3], b[4]}));
    end
    results();
  end

  // Watchdog, well beyond the thousand or so cycles the scenarios need
  initial begin
    #300000;
    errors++;
    results();
  end
endmodule
